/* verilog/dmamc_pkg.sv */
// Constants for the dual-controller mask and mode register block
package dmamc_pkg;

  localparam int unsigned DMAMC_NUM_CTL = 2;
  localparam int unsigned DMAMC_CH_PER_CTL = 4;
  localparam int unsigned DMAMC_NUM_CH = 8;

  // I/O port addresses, first controller
  localparam logic [15:0] DMAMC_CTL1_SINGLE_MASK = 16'h000a;
  localparam logic [15:0] DMAMC_CTL1_CHANNEL_MODE = 16'h000b;
  localparam logic [15:0] DMAMC_CTL1_CLEAR_BYTE_POINTER = 16'h000c;
  localparam logic [15:0] DMAMC_CTL1_MASTER_CLEAR = 16'h000d;
  localparam logic [15:0] DMAMC_CTL1_CLEAR_ALL_MASKS = 16'h000e;
  localparam logic [15:0] DMAMC_CTL1_WRITE_ALL_MASKS = 16'h000f;
  localparam logic [15:0] DMAMC_CTL1_ADDR_CNT_FIRST = 16'h0000;
  localparam logic [15:0] DMAMC_CTL1_ADDR_CNT_LAST = 16'h0007;

  // I/O port addresses, second controller (even ports only)
  localparam logic [15:0] DMAMC_CTL2_SINGLE_MASK = 16'h00d4;
  localparam logic [15:0] DMAMC_CTL2_CHANNEL_MODE = 16'h00d6;
  localparam logic [15:0] DMAMC_CTL2_CLEAR_BYTE_POINTER = 16'h00d8;
  localparam logic [15:0] DMAMC_CTL2_MASTER_CLEAR = 16'h00da;
  localparam logic [15:0] DMAMC_CTL2_CLEAR_ALL_MASKS = 16'h00dc;
  localparam logic [15:0] DMAMC_CTL2_WRITE_ALL_MASKS = 16'h00de;
  localparam logic [15:0] DMAMC_CTL2_ADDR_CNT_FIRST = 16'h00c0;
  localparam logic [15:0] DMAMC_CTL2_ADDR_CNT_LAST = 16'h00ce;

  localparam logic [15:0] DMAMC_MODE_SHADOW_COPY = 16'hb872;

  // Field positions
  localparam int unsigned DMAMC_SMASK_SET_BIT = 2;
  localparam int unsigned DMAMC_MODE_TMODE_LSB = 6;
  localparam int unsigned DMAMC_MODE_STEP_DOWN_BIT = 5;
  localparam int unsigned DMAMC_MODE_AUTO_BIT = 4;
  localparam int unsigned DMAMC_MODE_TTYPE_LSB = 2;

  // Values after reset
  localparam logic [3:0] DMAMC_MASK_RESET = 4'hf;
  localparam logic [7:0] DMAMC_MODE_RESET = 8'h00;
  localparam logic [7:0] DMAMC_SHADOW_RESET = 8'h00;
  localparam logic [15:0] DMAMC_RDATA_RESET = 16'h0000;

  typedef enum logic [1:0] {
    DMAMC_XFER_DEMAND = 2'b00,
    DMAMC_XFER_SINGLE = 2'b01,
    DMAMC_XFER_BLOCK = 2'b10,
    DMAMC_XFER_CASCADE = 2'b11
  } dmamc_xfer_mode_t;

  typedef enum logic [1:0] {
    DMAMC_TYPE_VERIFY = 2'b00,
    DMAMC_TYPE_WRITE = 2'b01,
    DMAMC_TYPE_READ = 2'b10,
    DMAMC_TYPE_UNUSED = 2'b11
  } dmamc_xfer_type_t;

endpackage : dmamc_pkg

/* verilog/dmamc_port_decode.sv */
// Port address decoder for both controllers and the mode shadow
`timescale 1ns/100ps
module dmamc_port_decode (
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [1:0] single_mask_wr,
  output logic [1:0] mode_wr,
  output logic [1:0] clear_ptr_wr,
  output logic [1:0] master_clear_wr,
  output logic [1:0] clear_masks_wr,
  output logic [1:0] all_masks_wr,
  output logic [1:0] addr_cnt_access,
  output logic shadow_rd
);

  function automatic logic hit(input logic [15:0] a, input logic [15:0] port);
    hit = (a == port);
  endfunction : hit

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  always_comb begin
    single_mask_wr[0] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL1_SINGLE_MASK);
    single_mask_wr[1] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL2_SINGLE_MASK);
    mode_wr[0] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL1_CHANNEL_MODE);
    mode_wr[1] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL2_CHANNEL_MODE);
    clear_ptr_wr[0] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL1_CLEAR_BYTE_POINTER);
    clear_ptr_wr[1] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL2_CLEAR_BYTE_POINTER);
    master_clear_wr[0] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL1_MASTER_CLEAR);
    master_clear_wr[1] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL2_MASTER_CLEAR);
    clear_masks_wr[0] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL1_CLEAR_ALL_MASKS);
    clear_masks_wr[1] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL2_CLEAR_ALL_MASKS);
    all_masks_wr[0] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL1_WRITE_ALL_MASKS);
    all_masks_wr[1] = io_wr && hit(io_addr, dmamc_pkg::DMAMC_CTL2_WRITE_ALL_MASKS);
    // Any read or write of an address or count port
    addr_cnt_access[0] = (io_wr || io_rd) && in_range(io_addr,
      dmamc_pkg::DMAMC_CTL1_ADDR_CNT_FIRST, dmamc_pkg::DMAMC_CTL1_ADDR_CNT_LAST);
    // Second controller sits on even ports only
    addr_cnt_access[1] = (io_wr || io_rd) && !io_addr[0] && in_range(io_addr,
      dmamc_pkg::DMAMC_CTL2_ADDR_CNT_FIRST, dmamc_pkg::DMAMC_CTL2_ADDR_CNT_LAST);
    // Read strobe only; a write here decodes to nothing
    shadow_rd = io_rd && hit(io_addr, dmamc_pkg::DMAMC_MODE_SHADOW_COPY);
  end

endmodule : dmamc_port_decode

/* verilog/dmamc_top.sv */
// Mask, mode, byte pointer and mode shadow logic for two DMA controllers
`timescale 1ns/100ps
module dmamc_top #(
  parameter int unsigned NUM_CH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [15:0] io_rdata,
  input wire logic [7:0] dma_request,
  input wire logic [7:0] count_end_reached,
  output logic [7:0] service_request,
  output logic [7:0] channel_mask,
  output logic [15:0] transfer_mode_field,
  output logic [7:0] address_step_down,
  output logic [7:0] autoinit_enable,
  output logic [15:0] transfer_type_field,
  output logic [7:0] transfer_type_unused,
  output logic [1:0] byte_pointer_high,
  output logic [1:0] controller_clear
);

  // Channel count is fixed by the two-controller port map
  if (NUM_CH != dmamc_pkg::DMAMC_NUM_CH) begin : g_bad_ch
    $error("dmamc_top supports exactly eight channels");
  end

  typedef struct packed {
    logic [7:0] req_meta;
    logic [7:0] req_sync;
    logic [7:0] svc;
    logic [7:0] mask;
    logic [7:0][7:0] mode;
    logic [1:0] ptr;
    logic [1:0][7:0] shadow;
    logic [1:0] clr;
    logic [15:0] rdata;
  } dmamc_state_t;

  dmamc_state_t q;
  dmamc_state_t d;

  logic [1:0] single_mask_wr;
  logic [1:0] mode_wr;
  logic [1:0] clear_ptr_wr;
  logic [1:0] master_clear_wr;
  logic [1:0] clear_masks_wr;
  logic [1:0] all_masks_wr;
  logic [1:0] addr_cnt_access;
  logic shadow_rd;

  dmamc_port_decode u_decode (
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_rd(io_rd),
    .single_mask_wr(single_mask_wr),
    .mode_wr(mode_wr),
    .clear_ptr_wr(clear_ptr_wr),
    .master_clear_wr(master_clear_wr),
    .clear_masks_wr(clear_masks_wr),
    .all_masks_wr(all_masks_wr),
    .addr_cnt_access(addr_cnt_access),
    .shadow_rd(shadow_rd)
  );

  localparam dmamc_state_t STATE_RESET = '{
    req_meta: 8'h00,
    req_sync: 8'h00,
    svc: 8'h00,
    mask: {dmamc_pkg::DMAMC_MASK_RESET, dmamc_pkg::DMAMC_MASK_RESET},
    mode: {8{dmamc_pkg::DMAMC_MODE_RESET}},
    ptr: 2'b00,
    shadow: {2{dmamc_pkg::DMAMC_SHADOW_RESET}},
    clr: 2'b00,
    rdata: dmamc_pkg::DMAMC_RDATA_RESET
  };

  always_comb begin
    d = q;
    // Request pins are asynchronous; two stages before use
    d.req_meta = dma_request;
    d.req_sync = q.req_meta;
    d.clr = 2'b00;
    for (int c = 0; c < 2; c++) begin
      // Only bits 2:0 looked at; 7:3 have no effect
      if (single_mask_wr[c]) begin
        // One bit moves, the others hold
        d.mask[c * 4 + int'(io_wdata[1:0])] = io_wdata[dmamc_pkg::DMAMC_SMASK_SET_BIT];
      end
      if (clear_masks_wr[c]) begin
        d.mask[c * 4 +: 4] = 4'h0;
      end
      if (all_masks_wr[c]) begin
        d.mask[c * 4 +: 4] = io_wdata[3:0];
      end
      if (mode_wr[c]) begin
        // Whole byte kept per channel; fields are sliced at the outputs
        d.mode[c * 4 + int'(io_wdata[1:0])] = io_wdata;
        d.shadow[c] = io_wdata;
      end
      // Independent pointer per controller
      if (clear_ptr_wr[c] || master_clear_wr[c]) begin
        d.ptr[c] = 1'b0;
      end else if (addr_cnt_access[c]) begin
        d.ptr[c] = ~q.ptr[c];
      end
      if (master_clear_wr[c]) begin
        d.mask[c * 4 +: 4] = dmamc_pkg::DMAMC_MASK_RESET;
        d.clr[c] = 1'b1;
      end
    end
    // Applied last so a count end beats a same-cycle mask clear
    for (int ch = 0; ch < 8; ch++) begin
      if (count_end_reached[ch] && !q.mode[ch][dmamc_pkg::DMAMC_MODE_AUTO_BIT]) begin
        d.mask[ch] = 1'b1;
      end
    end
    d.svc = q.req_sync & ~q.mask;
    if (shadow_rd) begin
      d.rdata = {q.shadow[0], q.shadow[1]};
    end else if (io_rd) begin
      d.rdata = dmamc_pkg::DMAMC_RDATA_RESET;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  for (genvar ch = 0; ch < 8; ch++) begin : g_ch
    assign transfer_mode_field[ch * 2 +: 2] =
      q.mode[ch][dmamc_pkg::DMAMC_MODE_TMODE_LSB +: 2];
    assign address_step_down[ch] = q.mode[ch][dmamc_pkg::DMAMC_MODE_STEP_DOWN_BIT];
    assign autoinit_enable[ch] = q.mode[ch][dmamc_pkg::DMAMC_MODE_AUTO_BIT];
    assign transfer_type_field[ch * 2 +: 2] =
      q.mode[ch][dmamc_pkg::DMAMC_MODE_TTYPE_LSB +: 2];
    // Flags the unused code instead of guessing a transfer type
    assign transfer_type_unused[ch] = (q.mode[ch][dmamc_pkg::DMAMC_MODE_TTYPE_LSB +: 2]
      == dmamc_pkg::DMAMC_TYPE_UNUSED);
  end

  assign service_request = q.svc;
  assign channel_mask = q.mask;
  assign byte_pointer_high = q.ptr;
  assign controller_clear = q.clr;
  assign io_rdata = q.rdata;

endmodule : dmamc_top

/* dv/dmamc_props.sv */
// Concurrent checks on the mask, mode, pointer and shadow ports
`timescale 1ns/100ps
module dmamc_props #(
  parameter int unsigned NUM_CH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_rdata,
  input wire logic [7:0] dma_request,
  input wire logic [7:0] count_end_reached,
  input wire logic [7:0] transfer_type_unused,
  input wire logic [7:0] service_request,
  input wire logic [7:0] channel_mask,
  input wire logic [7:0] autoinit_enable,
  input wire logic [1:0] byte_pointer_high,
  input wire logic [1:0] controller_clear
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [15:0] shd_q;
  wire [7:0] ce_set = count_end_reached & ~autoinit_enable;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) shd_q <= 16'h0000;
    else if (io_wr && io_addr == 16'h000b) shd_q[15:8] <= io_wdata;
    else if (io_wr && io_addr == 16'h00d6) shd_q[7:0] <= io_wdata;
  end
  // Count end may set a mask in the same cycle, so such writes are left out
  sequence s_wr(a);
    io_wr && io_addr == a && count_end_reached == 8'h00;
  endsequence
  a_single_mask: assert property (s_wr(16'h000a) |=>
    channel_mask[$past(io_wdata[1:0])] == $past(io_wdata[2])) else $error("single mask");
  a_clear_masks: assert property (s_wr(16'h00dc) |=> channel_mask[7:4] == 4'h0)
    else $error("clear all masks");
  a_write_masks: assert property (s_wr(16'h000f) |=>
    channel_mask[3:0] == $past(io_wdata[3:0])) else $error("write all masks");
  a_master_clear: assert property (s_wr(16'h000d) |=>
    channel_mask[3:0] == 4'hf && controller_clear == 2'b01 && !byte_pointer_high[0])
    else $error("master clear");
  a_ptr_clear: assert property (s_wr(16'h00d8) |=> !byte_pointer_high[1])
    else $error("pointer clear");
  a_ptr_toggle: assert property ((io_wr || io_rd) && io_addr <= 16'h0007 |=>
    byte_pointer_high[0] != $past(byte_pointer_high[0])) else $error("pointer toggle");
  a_shadow_read: assert property (io_rd && !io_wr && io_addr == 16'hb872 |=>
    io_rdata == $past(shd_q)) else $error("shadow read");
  a_count_end: assert property (ce_set != 8'h00 |=>
    (channel_mask & $past(ce_set)) == $past(ce_set)) else $error("count end mask");
  a_masked_idle: assert property ((service_request & channel_mask & $past(channel_mask))
    == 8'h00) else $error("masked channel serviced");
  // Three flops from pin to output; skip cycles whose history spans a reset
  a_service_pass: assert property ($past(rst_n, 4) |->
    service_request == ($past(dma_request, 3) & ~$past(channel_mask)))
    else $error("service request path");
  a_type_legal: assert property (transfer_type_unused == 8'h00)
    else $error("unused transfer type shown");
endmodule : dmamc_props

/* dv/dma_mask_mode_control_tb.sv */
// Self-checking bench for the mask, mode, pointer and shadow block
`timescale 1ns/100ps
module dma_mask_mode_control_tb;
  logic clock, rst_n, io_wr, io_rd, chk_q;
  logic [15:0] io_addr, io_rdata, transfer_mode_field, transfer_type_field, m_rd, m_shd;
  logic [7:0] io_wdata, dma_request, count_end_reached, service_request, channel_mask;
  logic [7:0] address_step_down, autoinit_enable, transfer_type_unused, m_mask;
  logic [1:0] byte_pointer_high, controller_clear, m_ptr, m_clr;
  logic [7:0] m_mode[8];
  logic [75:0] notes[$];
  int fails, samples_checked, seed, i;
  dmamc_top u_dmamc_top (.clock, .rst_n, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
    .dma_request, .count_end_reached, .service_request, .channel_mask, .transfer_mode_field,
    .address_step_down, .autoinit_enable, .transfer_type_field, .transfer_type_unused,
    .byte_pointer_high, .controller_clear);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [75:0] snap();
    logic [15:0] tm, tt;
    logic [7:0] sd, ai;
    for (int c = 0; c < 8; c++) begin
      tm[2*c+:2] = m_mode[c][7:6];
      tt[2*c+:2] = m_mode[c][3:2];
      sd[c] = m_mode[c][5];
      ai[c] = m_mode[c][4];
    end
    return {m_mask, m_ptr, m_clr, m_rd, tm, tt, sd, ai};
  endfunction : snap
  // Result shows one cycle after the access is taken
  always @(posedge clock) begin
    if (chk_q) begin
      samples_checked++;
      if (notes.size() == 0 || notes[0] !== {channel_mask, byte_pointer_high, controller_clear,
          io_rdata, transfer_mode_field, transfer_type_field, address_step_down,
          autoinit_enable}) begin
        fails++;
        $display("FAIL %0t port state differs", $time);
      end
      if (notes.size() != 0) void'(notes.pop_front());
    end
    chk_q <= io_wr | io_rd | (|count_end_reached);
  end
  // Leaves the request up so that calls run back to back
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    logic c;
    logic [3:0] p;
    c = a[7];
    p = c ? a[4:1] : a[3:0];
    @(posedge clock);
    io_wr <= wr;
    io_rd <= ~wr;
    io_addr <= a;
    io_wdata <= d;
    count_end_reached <= 8'h00;
    dma_request <= 8'($random(seed));
    m_clr = 2'b00;
    if (a[15:8] == 8'h00 && (c ? a[7:5] == 3'b110 && !a[0] : a[7:4] == 4'h0)) begin
      if (p < 4'h8) m_ptr[c] = ~m_ptr[c];
      if (wr && p == 4'ha) m_mask[{c, d[1:0]}] = d[2];
      if (wr && p == 4'hb) m_mode[{c, d[1:0]}] = d;
      if (wr && p == 4'hb) m_shd[(c ? 0 : 8)+:8] = d;
      if (wr && (p == 4'hc || p == 4'hd)) m_ptr[c] = 1'b0;
      if (wr && p == 4'hd) m_clr[c] = 1'b1;
      if (wr && p == 4'hd) m_mask[{c, 2'b00}+:4] = 4'hf;
      if (wr && p == 4'he) m_mask[{c, 2'b00}+:4] = 4'h0;
      if (wr && p == 4'hf) m_mask[{c, 2'b00}+:4] = d[3:0];
    end
    if (!wr) m_rd = (a == 16'hb872) ? m_shd : 16'h0000;
    notes.push_back(snap());
  endtask : acc
  task automatic cend(input int ch);
    @(posedge clock);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    count_end_reached <= 8'(1 << ch);
    m_clr = 2'b00;
    if (!m_mode[ch][4]) m_mask[ch] = 1'b1;
    notes.push_back(snap());
  endtask : cend
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      count_end_reached <= 8'h00;
    end
  endtask : idle
  task automatic do_reset();
    idle(1);
    rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    {m_mask, m_ptr, m_clr, m_rd, m_shd} = {8'hff, 36'h0};
    foreach (m_mode[k]) m_mode[k] = 8'h00;
  endtask : do_reset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    wrap_up();
  end
  initial begin
    {seed, fails, samples_checked, chk_q, rst_n} = {32'd50, 64'd0, 2'b00};
    {io_wr, io_rd, io_addr, io_wdata, dma_request, count_end_reached} = 42'h0;
    do_reset();
    acc(1'b0, 16'hb872, 8'h00);
    for (i = 0; i < 16; i++) acc(1'b1, i[0] ? 16'h00d6 : 16'h000b, {i[3:2], 2'($random(seed)), 2'(i % 3), i[2:1]});
    acc(1'b1, 16'hb872, 8'h5a);
    acc(1'b0, 16'hb872, 8'h00);
    $display("mode test done");
    for (i = 0; i < 24; i++) acc(1'b1, i[0] ? 16'h00d4 : 16'h000a, 8'($random(seed)));
    for (i = 0; i < 6; i++) acc(1'b1, i[0] ? 16'h00de : 16'h000f, 8'($random(seed)));
    acc(1'b1, 16'h000e, 8'ha5);
    acc(1'b1, 16'h00dc, 8'h00);
    for (i = 0; i < 8; i++) cend(i);
    $display("mask test done");
    for (i = 0; i < 12; i++) acc(i[1], i[0] ? 16'h00c0 + 16'(2 * (i % 8)) : 16'(i % 8), 8'h00);
    acc(1'b1, 16'h00c1, 8'h00);
    acc(1'b1, 16'h0010, 8'h00);
    acc(1'b0, 16'h0001, 8'h00);
    acc(1'b1, 16'h000c, 8'hff);
    acc(1'b0, 16'h00c2, 8'h00);
    acc(1'b1, 16'h00d8, 8'hff);
    acc(1'b1, 16'h0005, 8'h00);
    acc(1'b1, 16'h000d, 8'h3c);
    acc(1'b1, 16'h00da, 8'h00);
    $display("pointer test done");
    idle(3);
    do_reset();
    acc(1'b0, 16'hb872, 8'h00);
    idle(3);
    $display("reset test done");
    wrap_up();
  end
endmodule : dma_mask_mode_control_tb
bind dmamc_top dmamc_props #(.NUM_CH(NUM_CH)) u_dmamc_props (.clock, .rst_n, .io_addr,
  .io_wdata, .io_wr, .io_rd, .io_rdata, .dma_request, .count_end_reached,
  .transfer_type_unused, .service_request, .channel_mask,
  .autoinit_enable, .byte_pointer_high, .controller_clear);
